// [hdl/acd_pkg.sv]
// Package with constants and types for the analyzer clock distribution block.
//----------------------------------------------------------------------------------------------
// Summary of operation
// RULE_01 - Each of the four capture memory boards gets its own independent board tick.
// RULE_02 - Each board tick comes from the internal time base or an external clock.
// RULE_03 - A duplicate of every board tick feeds the trigger delay counter.
// RULE_04 - The master tick is one board tick, chosen by two select lines.
// RULE_05 - The trigger sequencer searches for triggers on the supplied master tick.
// RULE_06 - The time base offers 1-2-5 sample periods from 10 ns up to 500 ms; the code gives one 100 ns cycle for 10, 20 and 50 ns.
// RULE_07 - A fixed tick with a 10 ns period runs continuously; the code holds it high, one tick per 100 ns core cycle.
// RULE_08 - A fixed tick with a 100 ns period runs continuously for test patterns.
// RULE_09 - At the 10 ns resolution the memory boards run in interleave mode.
// RULE_10 - In interleave mode the gate blocks the board tick and enables both strobes.
// RULE_11 - The two phase strobes run at half rate and are 180 degrees apart.
// RULE_12 - Interleave mode is allowed only with the internal time base as source.
// RULE_13 - Board pairs 0/1 and 2/3 switch interleave independently with own strobes.
// RULE_14 - Interleave for each pair is enabled through a software control register.
// RULE_15 - Two probes each bring two clocks and six qualifiers; bit 0 is a clock.
// RULE_16 - Software reaches all registers over the slow controller bus.
// RULE_17 - Boards talk over a separate fast bus during capture and trigger search.
// RULE_18 - Software should define one master clock for mutually synchronous groups.
// RULE_19 - In synchronous multi-clock capture probe J line zero is the master.
// RULE_20 - Asynchronous capture uses each group's recording clock as its level master.
// RULE_21 - Two master ticks are available for use by different trigger levels.
// RULE_22 - Mixed synchronous and asynchronous triggering at once is not supported.
// RULE_23 - Adjacent external clocks may be OR-combined over two, three or four clocks.
// RULE_24 - Each external clock edge is qualified by its six qualifiers via a RAM.
// RULE_25 - An external clock period above 100 ms sets a readable slow-clock flag.
// RULE_26 - The two select lines form a binary index 0 to 3 of the board.
//----------------------------------------------------------------------------------------------
package acd_pkg;

	//------------------------------------------------------------------------------------------
	// Widths, timing and register map.
	//------------------------------------------------------------------------------------------
	localparam int          NUM_BOARDS      = 4;
	localparam int          NUM_PAIRS       = 2;
	localparam int          NUM_QUALS       = 6;
	localparam int          ADDR_W          = 3;
	localparam int          DATA_W          = 16;
	localparam int          CNT_W           = 24;
	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          TB_BASE_NS      = 10;
	localparam int          TB_STEPS        = 24;
	localparam int          FAST_PERIOD_NS  = 10;
	localparam int          PAT_PERIOD_NS   = 100;
	localparam int          SLOW_LIMIT_MS   = 100;
	localparam int          FAST_CYC        = (FAST_PERIOD_NS / CLK_PERIOD_NS) < 1 ? 1
	                                          : FAST_PERIOD_NS / CLK_PERIOD_NS;
	localparam int          PAT_CYC         = (PAT_PERIOD_NS / CLK_PERIOD_NS) < 1 ? 1
	                                          : PAT_PERIOD_NS / CLK_PERIOD_NS;
	localparam int          SLOW_LIMIT_CYC  = SLOW_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [2:0]  OFS_SOURCE      = 3'h0;
	localparam logic [2:0]  OFS_EXT_CFG     = 3'h1;
	localparam logic [2:0]  OFS_QRAM_ADDR   = 3'h2;
	localparam logic [2:0]  OFS_QRAM_DATA   = 3'h3;
	localparam logic [2:0]  OFS_STATUS      = 3'h4;
	localparam logic [15:0] RST_SOURCE      = 16'h0000;
	localparam logic [15:0] RST_EXT_CFG     = 16'h0000;
	localparam int          SRC_EXT_POS     = 0;
	localparam int          ILV_EN_POS      = 4;
	localparam int          TB_SEL_POS      = 6;
	localparam int          OR_LINK_POS     = 0;
	localparam int          EDGE_FALL_POS   = 4;

	// Register bus request from the controller.
	typedef struct packed {
		logic [2:0]  addr;
		logic [15:0] wdata;
		logic        we;
		logic        re;
	} acd_bus_req_t;

	// Interleave signals of one board pair.
	typedef struct packed {
		logic gate;
		logic phase_a;
		logic phase_b;
	} acd_ilv_t;

endpackage

// [hdl/acd_slow_detect.sv]
// Slow-clock detector that flags an external clock with too long a period.
`timescale 1ns/1ps
module acd_slow_detect #(
	parameter int LIMIT_CYC = acd_pkg::SLOW_LIMIT_CYC
) (
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Qualified clock event and flag.
	input  wire logic event_i,
	output logic      slow_o
);
	import acd_pkg::*;

	logic [CNT_W-1:0] gap_r;

	// Count cycles since the last event; saturate so the flag holds with no clock present.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gap_r <= '0;
		end else if (event_i) begin
			gap_r <= '0;
		end else if (gap_r <= CNT_W'(LIMIT_CYC)) begin
			gap_r <= gap_r + 1'b1;
		end
	end

	// The flag is set once the gap reaches the limit and falls with the next event.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			slow_o <= 1'b0;
		end else begin
			slow_o <= !event_i && (gap_r >= CNT_W'(LIMIT_CYC)); // see RULE_25
		end
	end

	slow_after_limit_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE_25
		(!event_i && gap_r >= CNT_W'(LIMIT_CYC)) |=> slow_o)
		else $error("slow flag not set after limit");

endmodule

// [hdl/acd_top.sv]
// Clock distribution core: time base, external clock qualification, board and master ticks.
`timescale 1ns/1ps
module acd_top #(
	parameter int SLOW_LIMIT = acd_pkg::SLOW_LIMIT_CYC,
	parameter int TB_CAP     = 5000000
) (
	// Clock and reset.
	input  wire logic                 CLK_I,
	input  wire logic                 RST_I,
	// Controller register port.
	input  wire acd_pkg::acd_bus_req_t REG_REQ_I,
	output logic [15:0]                REG_RDATA_O,
	// Clock probes, bits 0 and 1 are clocks, bits 2 to 7 qualifiers.
	input  wire logic [7:0]           PROBE_J_I,
	input  wire logic [7:0]           PROBE_K_I,
	// Master select pairs from the trigger level engine.
	input  wire logic [1:0]           MASTER_TICK_SELECT_A_I,
	input  wire logic [1:0]           MASTER_TICK_SELECT_B_I,
	// Ticks to capture memory boards and trigger level engine.
	output logic [3:0]                BOARD_TICK_O,
	output logic [3:0]                DELAY_COUNTER_TICK_O,
	output logic                      TRIGGER_MASTER_TICK_A_O,
	output logic                      TRIGGER_MASTER_TICK_B_O,
	output logic                      FIXED_FAST_TICK_O,
	output logic                      FIXED_PATTERN_TICK_O,
	// Interleave signals for pairs 0/1 and 2/3.
	output acd_pkg::acd_ilv_t         INTERLEAVE_PAIR0_O,
	output acd_pkg::acd_ilv_t         INTERLEAVE_PAIR1_O
);
	import acd_pkg::*;

	//------------------------------------------------------------------------------------------
	// Helper functions.
	//------------------------------------------------------------------------------------------

	// Cycles per time base period: 10 ns times 1, 2 or 5 times a power of ten.
	function automatic logic [CNT_W-1:0] tb_cycles(input logic [4:0] sel);
		int ns;
		int m;
		ns = TB_BASE_NS;
		m  = int'(sel) % 3;
		for (int d = 0; d < TB_STEPS / 3; d++) begin
			if (d < int'(sel) / 3) begin
				ns = ns * 10;
			end
		end
		ns = (m == 0) ? ns : (m == 1) ? ns * 2 : ns * 5;
		ns = ns / CLK_PERIOD_NS;
		if (ns < 1) begin
			ns = 1;
		end
		if (ns > TB_CAP) begin
			ns = TB_CAP;
		end
		return CNT_W'(ns);
	endfunction

	// Spread each qualified event over its run of OR-linked adjacent clocks.
	function automatic logic [3:0] or_combine(input logic [3:0] ev, input logic [2:0] link);
		logic [3:0] fwd;
		logic [3:0] bwd;
		fwd    = ev;
		bwd    = ev;
		for (int i = 1; i < NUM_BOARDS; i++) begin
			fwd[i] = ev[i] | (link[i-1] & fwd[i-1]);
		end
		for (int i = NUM_BOARDS - 2; i >= 0; i--) begin
			bwd[i] = ev[i] | (link[i] & bwd[i+1]);
		end
		return fwd | bwd;
	endfunction

	//------------------------------------------------------------------------------------------
	// Registers and state.
	//------------------------------------------------------------------------------------------
	logic [15:0]      source_r;
	logic [15:0]      ext_cfg_r;
	logic [7:0]       qram_addr_r;
	logic [255:0]     qram_r;
	logic [15:0]      rdata_nxt;
	logic [15:0]      status;
	logic [7:0]       pj_meta_r;
	logic [7:0]       pj_sync_r;
	logic [7:0]       pk_meta_r;
	logic [7:0]       pk_sync_r;
	logic [3:0]       clk_prev_r;
	logic [3:0]       ext_lvl;
	logic [3:0]       qual_ev;
	logic [3:0]       ext_ev;
	logic [3:0]       slow;
	logic [CNT_W-1:0] tb_cnt_r;
	logic             tb_tick;
	logic [1:0]       phase_r;
	logic [1:0]       ilv_act;
	logic [3:0]       board_nxt;
	logic [3:0]       ext_sel;
	acd_ilv_t         ilv_nxt [2];
	logic [1:0]       sel_a_r;

	assign ext_sel = source_r[SRC_EXT_POS +: 4];

	//------------------------------------------------------------------------------------------
	// Register port.
	//------------------------------------------------------------------------------------------

	// Control registers written by software.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			source_r  <= RST_SOURCE;
			ext_cfg_r <= RST_EXT_CFG;
		end else if (REG_REQ_I.we) begin
			if (REG_REQ_I.addr == OFS_SOURCE) begin
				source_r <= REG_REQ_I.wdata; // see RULE_02, see RULE_14
			end
			if (REG_REQ_I.addr == OFS_EXT_CFG) begin
				ext_cfg_r <= REG_REQ_I.wdata; // see RULE_23
			end
		end
	end

	// Qualifier RAM: one bit per clock and qualifier pattern, addressed indirectly.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			qram_addr_r <= 8'h00;
			qram_r      <= '0;
		end else if (REG_REQ_I.we) begin
			if (REG_REQ_I.addr == OFS_QRAM_ADDR) begin
				qram_addr_r <= REG_REQ_I.wdata[7:0];
			end
			if (REG_REQ_I.addr == OFS_QRAM_DATA) begin
				qram_r[qram_addr_r] <= REG_REQ_I.wdata[0]; // see RULE_24
			end
		end
	end

	// Status shows slow flags, active interleave pairs and external sources.
	assign status = {6'h00, ext_sel, ilv_act, slow};

	// Read decode; unmapped addresses read zero, data stand only in the following cycle.
	always_comb begin
		rdata_nxt = 16'h0000;
		if (REG_REQ_I.re) begin
			case (REG_REQ_I.addr)
				OFS_SOURCE:    rdata_nxt = source_r;
				OFS_EXT_CFG:   rdata_nxt = ext_cfg_r;
				OFS_QRAM_ADDR: rdata_nxt = {8'h00, qram_addr_r};
				OFS_QRAM_DATA: rdata_nxt = {15'h0000, qram_r[qram_addr_r]};
				OFS_STATUS:    rdata_nxt = status;
				default:       rdata_nxt = 16'h0000;
			endcase
		end
	end

	// Read data register.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			REG_RDATA_O <= 16'h0000;
		end else begin
			REG_RDATA_O <= rdata_nxt; // see RULE_16
		end
	end

	//------------------------------------------------------------------------------------------
	// External clock probes.
	//------------------------------------------------------------------------------------------

	// Two-stage synchronisers; probe pins are asynchronous to the core clock.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pj_meta_r <= 8'h00;
			pj_sync_r <= 8'h00;
			pk_meta_r <= 8'h00;
			pk_sync_r <= 8'h00;
		end else begin
			pj_meta_r <= PROBE_J_I;
			pj_sync_r <= pj_meta_r;
			pk_meta_r <= PROBE_K_I;
			pk_sync_r <= pk_meta_r;
		end
	end

	// External clocks in board order: J line zero, J line one, K line zero, K line one.
	assign ext_lvl = {pk_sync_r[1], pk_sync_r[0], pj_sync_r[1], pj_sync_r[0]}; // see RULE_15

	// Previous level for edge detection.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			clk_prev_r <= 4'h0;
		end else begin
			clk_prev_r <= ext_lvl;
		end
	end

	// Chosen edge of each clock, passed only if its qualifier pattern is enabled in the RAM.
	always_comb begin
		logic [5:0] q;
		logic       edge_seen;
		q         = 6'h00;
		edge_seen = 1'b0;
		for (int c = 0; c < NUM_BOARDS; c++) begin
			q = (c < 2) ? pj_sync_r[7:2] : pk_sync_r[7:2];
			edge_seen = ext_cfg_r[EDGE_FALL_POS + c] ? (clk_prev_r[c] & ~ext_lvl[c])
			                                          : (~clk_prev_r[c] & ext_lvl[c]);
			qual_ev[c] = edge_seen & qram_r[{2'(c), q}]; // see RULE_24
		end
	end

	assign ext_ev = or_combine(qual_ev, ext_cfg_r[OR_LINK_POS +: 3]); // see RULE_23

	// One slow-clock detector per external clock.
	for (genvar c = 0; c < NUM_BOARDS; c++) begin : g_slow
		acd_slow_detect #(
			.LIMIT_CYC(SLOW_LIMIT)
		) u_slow (
			.clk_i   (CLK_I),
			.rst_i   (RST_I),
			.event_i (ext_ev[c]),
			.slow_o  (slow[c])
		);
	end

	//------------------------------------------------------------------------------------------
	// Internal time base and fixed ticks.
	//------------------------------------------------------------------------------------------

	// Divider for the selected 1-2-5 period; one tick per period.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tb_cnt_r <= '0;
		end else if (tb_tick) begin
			tb_cnt_r <= '0;
		end else begin
			tb_cnt_r <= tb_cnt_r + 1'b1; // see RULE_06
		end
	end

	assign tb_tick = (tb_cnt_r + 1'b1) >= tb_cycles(source_r[TB_SEL_POS +: 5]);

	// Fixed ticks; at this core rate both periods collapse to one cycle, so they stay high.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			FIXED_FAST_TICK_O    <= 1'b0;
			FIXED_PATTERN_TICK_O <= 1'b0;
		end else begin
			FIXED_FAST_TICK_O    <= (FAST_CYC == 1); // see RULE_07
			FIXED_PATTERN_TICK_O <= (PAT_CYC == 1);  // see RULE_08
		end
	end

	//------------------------------------------------------------------------------------------
	// Interleave and board ticks.
	//------------------------------------------------------------------------------------------

	// A pair interleaves only if enabled and both boards use the internal time base.
	always_comb begin
		for (int p = 0; p < NUM_PAIRS; p++) begin
			ilv_act[p] = source_r[ILV_EN_POS + p] && (ext_sel[2*p +: 2] == 2'b00); // see RULE_12, see RULE_13
		end
	end

	// Phase toggles per time base tick so each strobe gets every second tick.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			phase_r <= 2'b00;
		end else begin
			for (int p = 0; p < NUM_PAIRS; p++) begin
				phase_r[p] <= !ilv_act[p] ? 1'b0 : (phase_r[p] ^ tb_tick); // see RULE_11
			end
		end
	end

	// Board tick source choice and interleave gating.
	always_comb begin
		for (int b = 0; b < NUM_BOARDS; b++) begin
			board_nxt[b] = ext_sel[b] ? ext_ev[b] : tb_tick; // see RULE_01, see RULE_02
			if (ilv_act[b/2]) begin
				board_nxt[b] = 1'b0; // see RULE_10
			end
		end
		for (int p = 0; p < NUM_PAIRS; p++) begin
			ilv_nxt[p].gate    = ilv_act[p];
			ilv_nxt[p].phase_a = ilv_act[p] & tb_tick & ~phase_r[p]; // see RULE_09, see RULE_11
			ilv_nxt[p].phase_b = ilv_act[p] & tb_tick & phase_r[p];
		end
	end

	// Board ticks and their copies for the trigger delay counter.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			BOARD_TICK_O         <= 4'h0;
			DELAY_COUNTER_TICK_O <= 4'h0;
		end else begin
			BOARD_TICK_O         <= board_nxt; // see RULE_01, see RULE_17
			DELAY_COUNTER_TICK_O <= board_nxt; // see RULE_03
		end
	end

	// Interleave outputs per pair.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			INTERLEAVE_PAIR0_O <= '0;
			INTERLEAVE_PAIR1_O <= '0;
		end else begin
			INTERLEAVE_PAIR0_O <= ilv_nxt[0];
			INTERLEAVE_PAIR1_O <= ilv_nxt[1];
		end
	end

	//------------------------------------------------------------------------------------------
	// Master ticks.
	//------------------------------------------------------------------------------------------

	// Two masters so trigger levels may run on two clock domains; the selects come
	// from same-clock logic and need no synchroniser. Mixed sync/async triggering
	// is left to software, which must not ask for it.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			TRIGGER_MASTER_TICK_A_O <= 1'b0;
			TRIGGER_MASTER_TICK_B_O <= 1'b0;
			sel_a_r                 <= 2'b00;
		end else begin
			TRIGGER_MASTER_TICK_A_O <= board_nxt[MASTER_TICK_SELECT_A_I]; // see RULE_04, see RULE_26
			TRIGGER_MASTER_TICK_B_O <= board_nxt[MASTER_TICK_SELECT_B_I]; // see RULE_21, see RULE_22
			sel_a_r                 <= MASTER_TICK_SELECT_A_I;
		end
	end

	//------------------------------------------------------------------------------------------
	// Assertions.
	//------------------------------------------------------------------------------------------
	master_follows_sel_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE_26
		TRIGGER_MASTER_TICK_A_O == BOARD_TICK_O[sel_a_r])
		else $error("master tick does not match selected board");

	delay_copy_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE_03
		DELAY_COUNTER_TICK_O == BOARD_TICK_O)
		else $error("delay counter tick differs from board tick");

	ilv_blocks_board_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE_10
		INTERLEAVE_PAIR0_O.gate |-> BOARD_TICK_O[1:0] == 2'b00)
		else $error("board tick passes while interleave gate is high");

	ilv_internal_only_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE_12
		ext_sel[3:2] != 2'b00 |=> !INTERLEAVE_PAIR1_O.gate)
		else $error("interleave active with external source");

	phase_alternate_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE_11
		(INTERLEAVE_PAIR0_O.phase_a && $stable(source_r)) |-> !INTERLEAVE_PAIR0_O.phase_b)
		else $error("phase strobes overlap");

	phase_half_rate_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE_11
		(ilv_act[0] && tb_tick && !phase_r[0]) |=> phase_r[0])
		else $error("phase does not toggle on tick");

	source_select_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE_02
		(ext_sel[0] && !ilv_act[0]) |=> BOARD_TICK_O[0] == $past(ext_ev[0]))
		else $error("external board tick not passed");

	fast_tick_run_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE_07
		!$past(RST_I) |-> FIXED_FAST_TICK_O && FIXED_PATTERN_TICK_O)
		else $error("fixed fast tick stopped");

	unmapped_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I) // see RULE_16
		(REG_REQ_I.re && REG_REQ_I.addr > OFS_STATUS) |=> REG_RDATA_O == 16'h0000)
		else $error("unmapped read not zero");

	cov_interleave_c: cover property (@(posedge CLK_I) disable iff (RST_I)
		INTERLEAVE_PAIR0_O.phase_a ##[1:20] INTERLEAVE_PAIR0_O.phase_b);
	cov_external_c: cover property (@(posedge CLK_I) disable iff (RST_I)
		ext_sel[2] && BOARD_TICK_O[2]);
	cov_or_link_c: cover property (@(posedge CLK_I) disable iff (RST_I)
		ext_ev[3] && !qual_ev[3]);

endmodule

// [verification/acd_seq_model.sv]
// Behavioural trigger sequencer that picks the master ticks and counts master tick A.
`timescale 1ns/1ps
module acd_seq_model (
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Scan request from the bench and master tick A from the block.
	input  wire logic scan_i,
	input  wire logic tick_a_i,
	// Master select pairs towards the block and the search count.
	output logic [1:0] sel_a_o,
	output logic [1:0] sel_b_o,
	output int         hits_o
);
	// Select A rests on board 0, the J0 board; a scan walks all four indices.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sel_a_o <= 2'h0;
		end else if (scan_i) begin
			sel_a_o <= sel_a_o + 2'h1;
		end else begin
			sel_a_o <= 2'h0;
		end
	end
	// The second master always sits on another board, so two domains can be searched.
	assign sel_b_o = ~sel_a_o;
	// The search advances only on the supplied master tick, never on the core clock alone.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hits_o <= 0;
		end else if (tick_a_i) begin
			hits_o <= hits_o + 1;
		end
	end
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the analyzer clock distribution block.
`timescale 1ns/1ps
module tb_top;
	import acd_pkg::*;
	//--------------------------------------------------------------------------
	// Signals
	//--------------------------------------------------------------------------
	logic         clk;
	logic         rst;
	acd_bus_req_t req;
	logic [15:0]  rdata;
	logic [7:0]   pj;
	logic [7:0]   pk;
	logic         scan;
	logic [1:0]   sel_a;
	logic [1:0]   sel_b;
	logic [3:0]   board;
	logic [3:0]   delay;
	logic         ma;
	logic         mb;
	logic         fast;
	logic         pat;
	acd_ilv_t     ilv0;
	acd_ilv_t     ilv1;
	int           hits;
	int           fails = 0;
	int           checks_done = 0;
	int           per_tab[9] = '{1, 1, 1, 1, 2, 5, 10, 20, 50};
	//--------------------------------------------------------------------------
	// Design and partner
	//--------------------------------------------------------------------------
	// Short slow limit and time base cap keep the run brief.
	acd_top #(.SLOW_LIMIT(50), .TB_CAP(64)) i_dut (
		.CLK_I(clk), .RST_I(rst), .REG_REQ_I(req), .REG_RDATA_O(rdata),
		.PROBE_J_I(pj), .PROBE_K_I(pk), .MASTER_TICK_SELECT_A_I(sel_a), .MASTER_TICK_SELECT_B_I(sel_b),
		.BOARD_TICK_O(board), .DELAY_COUNTER_TICK_O(delay), .TRIGGER_MASTER_TICK_A_O(ma),
		.TRIGGER_MASTER_TICK_B_O(mb), .FIXED_FAST_TICK_O(fast), .FIXED_PATTERN_TICK_O(pat),
		.INTERLEAVE_PAIR0_O(ilv0), .INTERLEAVE_PAIR1_O(ilv1));
	acd_seq_model i_model (
		.clk_i(clk), .rst_i(rst), .scan_i(scan), .tick_a_i(ma), .sel_a_o(sel_a), .sel_b_o(sel_b), .hits_o(hits));
	// Clock at 10 MHz.
	always #50 clk = ~clk;
	//--------------------------------------------------------------------------
	// Shared tasks
	//--------------------------------------------------------------------------
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d, checks %0d", fails, checks_done);
		if (fails == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Sampling just after the edge lets that edge's updates land first.
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic wr(logic [2:0] a, logic [15:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk);
		req <= '0;
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(logic [2:0] a, logic [15:0] m, logic [15:0] e, string what);
		@(posedge clk);
		req <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
		@(posedge clk);
		req <= '0;
		#1;
		chk(what, rdata & m, e);
	endtask
	task automatic wait_tick(output int n);
		n = 0;
		do begin
			step();
			n++;
		end while (board[0] !== 1'b1 && n < 200);
		if (n >= 200) begin
			fails++;
			close_out();
		end
	endtask
	// The edges at cycle 4 and at cycle 11 are the rise and fall of J0.
	task automatic j0_run(logic [5:0] q, logic [15:0] e, string what);
		int n;
		n = 0;
		for (int c = 0; c < 18; c++) begin
			@(posedge clk);
			pj <= {q, (c >= 4 && c < 11) ? 2'b01 : 2'b00};
			#1;
			n += (board[0] === 1'b1) ? 1 : 0;
		end
		chk(what, 16'(n), e);
	endtask
	//--------------------------------------------------------------------------
	// Scenarios
	//--------------------------------------------------------------------------
	task automatic t_reset();
		step();
		chk("fast tick", {15'h0, fast}, 16'h0001);
		chk("pattern tick", {15'h0, pat}, 16'h0001);
		rd(OFS_SOURCE, 16'hffff, RST_SOURCE, "source reset");
		rd(OFS_EXT_CFG, 16'hffff, RST_EXT_CFG, "ext cfg reset");
		wr(3'h6, 16'hffff);
		rd(3'h6, 16'hffff, 16'h0000, "unmapped read");
		wr(OFS_EXT_CFG, 16'h0017);
		rd(OFS_EXT_CFG, 16'h00f7, 16'h0017, "ext cfg");
		wr(OFS_EXT_CFG, 16'h0000);
		repeat (60) step();
		rd(OFS_STATUS, 16'h0001, 16'h0001, "slow flag set");
	endtask
	task automatic t_timebase();
		int n;
		for (int i = 0; i < 9; i++) begin
			wr(OFS_SOURCE, 16'(i) << TB_SEL_POS);
			wait_tick(n);
			wait_tick(n);
			wait_tick(n);
			chk("tick period", 16'(n), 16'(per_tab[i]));
			chk("all boards", {12'h0, board}, 16'h000f);
			chk("delay copy", {12'h0, delay}, 16'h000f);
		end
	endtask
	// Only board 0 ticks, so a wrong index shows up as a missing or stray tick.
	task automatic t_master();
		logic [1:0] pa;
		logic [1:0] pb;
		wr(OFS_SOURCE, 16'h000e | (16'h0005 << TB_SEL_POS));
		scan <= 1'b1;
		#1;
		for (int c = 0; c < 40; c++) begin
			pa = sel_a;
			pb = sel_b;
			step();
			chk("master a", {15'h0, ma}, {15'h0, board[pa]});
			chk("master b", {15'h0, mb}, {15'h0, board[pb]});
		end
		@(posedge clk);
		scan <= 1'b0;
		chk("master hits", {15'h0, hits != 0}, 16'h0001);
	endtask
	task automatic t_ext();
		wr(OFS_SOURCE, 16'h0001);
		wr(OFS_QRAM_ADDR, 16'h0015);
		wr(OFS_QRAM_DATA, 16'h0000);
		wr(OFS_QRAM_ADDR, 16'h002a);
		wr(OFS_QRAM_DATA, 16'h0001);
		rd(OFS_QRAM_DATA, 16'h0001, 16'h0001, "qram readback");
		j0_run(6'h2a, 16'h0001, "rising qualified");
		j0_run(6'h15, 16'h0000, "rising refused");
		wr(OFS_EXT_CFG, 16'h0001 << EDGE_FALL_POS);
		j0_run(6'h2a, 16'h0001, "falling qualified");
		rd(OFS_STATUS, 16'h0001, 16'h0000, "slow flag clear");
	endtask
	// Pair 1 asks for interleave with board 2 external, which must be ignored.
	task automatic t_ilv();
		logic pa_prev;
		wr(OFS_SOURCE, 16'h0034);
		rd(OFS_STATUS, 16'h03f0, 16'h0110, "interleave status");
		step();
		pa_prev = ilv0.phase_a;
		for (int c = 0; c < 8; c++) begin
			step();
			chk("pair0 gate", {15'h0, ilv0.gate}, 16'h0001);
			chk("pair1 gate and phases", {13'h0, ilv1}, 16'h0000);
			chk("pair0 boards", {14'h0, board[1:0]}, 16'h0000);
			chk("phase split", {14'h0, ilv0.phase_a, ilv0.phase_b}, {14'h0, ~pa_prev, pa_prev});
			pa_prev = ilv0.phase_a;
		end
	endtask
	//--------------------------------------------------------------------------
	// Main sequence and watchdog
	//--------------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		req = '0;
		pj = 8'h00;
		pk = 8'h00;
		scan = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_timebase();
		t_master();
		t_ext();
		t_ilv();
		close_out();
	end
	// A hang anywhere counts as a mismatch.
	initial begin
		#2000000;
		fails++;
		close_out();
	end
endmodule
